// *** pbp_byte_port.sv ***
// device end of the eight-bit peripheral byte port
// How it works
// - eight-bit two-way bus, bytes in, status out
// - host bytes carry text, data and commands
// - sample bus while read strobe held low
// - drive status byte while status strobe low
// - status strobe only for new status
// - capture bus on write strobe rising edge
// - ready_n high while busy, low when free
// - ready_n pulses high after every write
// - ready_n stays high while buffer full
// - ready state mirrored in status bit four
// - written bytes queue in eight-kilobyte buffer
`timescale 1ns/1ns
module pbp_byte_port #(
  parameter int BUF_DEPTH = pbp_pkg::BUF_DEPTH_DEF
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // peripheral byte bus pins
  input  wire logic [7:0] PERIPH_BYTE_BUS_I,
  output logic [7:0]      PERIPH_BYTE_BUS_O,
  output logic            PERIPH_BYTE_BUS_OE,
  output logic            STATUS_STROBE_N,
  output logic            PERIPH_READ_STROBE_N,
  input  wire logic       HOST_WRITE_STROBE_N,
  output logic            READY_N,
  // fetch request from the processing core
  input  wire logic       FETCH_REQ,
  output logic            FETCH_BUSY,
  // new status from the processing core
  input  wire logic       STATUS_VALID,
  input  wire logic [7:0] STATUS_DATA,
  // byte stream to the processing core
  output logic            BYTE_VALID,
  input  wire logic       BYTE_READY,
  output logic [7:0]      BYTE_DATA,
  // write taken while the buffer was full
  output logic            WRITE_DROP
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  generate
    if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("pbp_byte_port needs BUF_DEPTH of at least 2");
    end
  endgenerate

  localparam logic [pbp_pkg::TIMER_W-1:0] STROBE_LOAD =
    pbp_pkg::TIMER_W'(pbp_pkg::STROBE_CYC - 1);
  localparam logic [pbp_pkg::TIMER_W-1:0] ACK_LOAD =
    pbp_pkg::TIMER_W'(pbp_pkg::ACK_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                          wr_n_prev_q;
  logic                          host_rise;
  pbp_pkg::pbp_byte_xfer_type    push;
  logic                          buf_ready;
  logic [pbp_pkg::TIMER_W-1:0]   ack_cnt_q;
  logic                          busy;
  logic                          busy_prev_q;
  logic                          stat_pend_q;
  logic [7:0]                    stat_byte_q;
  logic                          stat_set;
  logic                          stat_take;
  pbp_pkg::pbp_phase_type        phase_q;
  logic [pbp_pkg::TIMER_W-1:0]   phase_cnt_q;
  logic                          fetch_done;
  logic [7:0]                    bus_o_q;
  logic                          bus_oe_q;
  logic                          status_n_q;
  logic                          read_n_q;
  logic                          drop_q;

  ////////////////////////////////////////////////////////////////////////////
  // host write edge

  // remember last strobe level to find its rising edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_n_prev_q <= 1'b1;
    end else begin
      wr_n_prev_q <= HOST_WRITE_STROBE_N;
    end
  end

  assign host_rise = HOST_WRITE_STROBE_N && !wr_n_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // buffer push arbitration

  // a host write owns the push port; a pending fetch waits a cycle
  always_comb begin
    push.valid = 1'b0;
    push.data  = pbp_pkg::BYTE_RST;
    if (host_rise) begin
      push.valid = 1'b1;
      push.data  = PERIPH_BYTE_BUS_I;
    end else if (fetch_done) begin
      push.valid = 1'b1;
      push.data  = PERIPH_BYTE_BUS_I;
    end
  end

  // input buffer between the bus and the processing core
  pbp_fifo #(
    .WIDTH (pbp_pkg::BYTE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (push.valid),
    .in_ready  (buf_ready),
    .in_data   (push.data),
    .out_valid (BYTE_VALID),
    .out_ready (BYTE_READY),
    .out_data  (BYTE_DATA)
  );

  // flag a host write that found no room
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= host_rise && !buf_ready;
    end
  end

  assign WRITE_DROP = drop_q;

  ////////////////////////////////////////////////////////////////////////////
  // ready indication

  // acknowledge pulse after every write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_cnt_q <= '0;
    end else if (host_rise) begin
      ack_cnt_q <= ACK_LOAD;
    end else if (ack_cnt_q != '0) begin
      ack_cnt_q <= ack_cnt_q - 1'b1;
    end
  end

  // busy while acknowledging or while the buffer has no room
  assign busy    = (ack_cnt_q != '0) || !buf_ready;
  assign READY_N = busy;

  ////////////////////////////////////////////////////////////////////////////
  // status tracking

  // a change of ready state counts as new status
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_prev_q <= 1'b0;
    end else begin
      busy_prev_q <= busy;
    end
  end

  assign stat_set  = STATUS_VALID || (busy != busy_prev_q);
  assign stat_take = (phase_q == pbp_pkg::PH_IDLE) && stat_pend_q;

  // pending flag: a new event wins over the take in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_pend_q <= 1'b0;
    end else begin
      stat_pend_q <= stat_set || (stat_pend_q && !stat_take);
    end
  end

  // latest status byte from the core
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_byte_q <= pbp_pkg::BYTE_RST;
    end else if (STATUS_VALID) begin
      stat_byte_q <= STATUS_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus phase sequencer

  // the fetch ends when its time is up and the push port is free
  assign fetch_done = (phase_q == pbp_pkg::PH_FETCH) && (phase_cnt_q == '0)
                      && !host_rise && buf_ready;
  assign FETCH_BUSY = (phase_q == pbp_pkg::PH_FETCH);

  // status has priority over fetching; phases never overlap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_q     <= pbp_pkg::PH_IDLE;
      phase_cnt_q <= '0;
    end else begin
      unique case (phase_q)
        pbp_pkg::PH_IDLE: begin
          if (stat_pend_q) begin
            phase_q     <= pbp_pkg::PH_STATUS;
            phase_cnt_q <= STROBE_LOAD;
          end else if (FETCH_REQ && buf_ready) begin
            phase_q     <= pbp_pkg::PH_FETCH;
            phase_cnt_q <= STROBE_LOAD;
          end
        end
        pbp_pkg::PH_FETCH: begin
          if (phase_cnt_q != '0) begin
            phase_cnt_q <= phase_cnt_q - 1'b1;
          end else if (fetch_done) begin
            phase_q <= pbp_pkg::PH_IDLE;
          end
        end
        pbp_pkg::PH_STATUS: begin
          if (phase_cnt_q != '0) begin
            phase_cnt_q <= phase_cnt_q - 1'b1;
          end else begin
            phase_q <= pbp_pkg::PH_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe and bus drivers

  // read strobe low through the whole fetch phase
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      read_n_q <= 1'b1;
    end else if (phase_q == pbp_pkg::PH_IDLE && !stat_pend_q && FETCH_REQ && buf_ready) begin
      read_n_q <= 1'b0;
    end else if (fetch_done) begin
      read_n_q <= 1'b1;
    end
  end

  // status strobe falls as output enable rises, and rises as it falls, on the same edges
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_n_q <= 1'b1;
      bus_oe_q   <= 1'b0;
    end else if (stat_take) begin
      status_n_q <= 1'b0;
      bus_oe_q   <= 1'b1;
    end else if (phase_q == pbp_pkg::PH_STATUS && phase_cnt_q == '0) begin
      status_n_q <= 1'b1;
      bus_oe_q   <= 1'b0;
    end
  end

  // status byte with the ready state in its ready bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus_o_q <= pbp_pkg::BYTE_RST;
    end else if (stat_take) begin
      bus_o_q                     <= stat_byte_q;
      bus_o_q[pbp_pkg::READY_BIT] <= busy;
    end
  end

  // pin drivers
  assign PERIPH_BYTE_BUS_O    = bus_o_q;
  assign PERIPH_BYTE_BUS_OE   = bus_oe_q;
  assign STATUS_STROBE_N      = status_n_q;
  assign PERIPH_READ_STROBE_N = read_n_q;

endmodule : pbp_byte_port

// *** pbp_checker.sv ***
// pin checker for the peripheral byte port
`timescale 1ns/1ns
module pbp_checker (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // bus and strobes
  input wire logic [7:0] PERIPH_BYTE_BUS_O,
  input wire logic       PERIPH_BYTE_BUS_OE,
  input wire logic       STATUS_STROBE_N,
  input wire logic       PERIPH_READ_STROBE_N,
  input wire logic       HOST_WRITE_STROBE_N,
  // pacing and core side
  input wire logic       READY_N,
  input wire logic       STATUS_VALID,
  input wire logic       WRITE_DROP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic wr_q, rdy_q, sts_q, ev_q, evt_q, wr, ev;
  ////////////////////////////////////////
  // host write edge and pending status events
  assign wr = HOST_WRITE_STROBE_N && !wr_q;
  assign ev = STATUS_VALID || (READY_N != rdy_q);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_q  <= 1'b1;
      rdy_q <= 1'b0;
      sts_q <= 1'b1;
      ev_q  <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      wr_q  <= HOST_WRITE_STROBE_N;
      rdy_q <= READY_N;
      sts_q <= STATUS_STROBE_N;
      ev_q  <= ev;
      evt_q <= ev || ((!STATUS_STROBE_N && sts_q) ? ev_q : evt_q);
    end
  end
  ////////////////////////////////////////
  // status phase
  property p_oe_sts; PERIPH_BYTE_BUS_OE == !STATUS_STROBE_N; endproperty
  a_oe_sts: assert property (p_oe_sts)
    else $error("bus enable differs from status strobe");
  property p_sts_len; $fell(STATUS_STROBE_N) |=> !STATUS_STROBE_N [*4] ##1 STATUS_STROBE_N;
  endproperty
  a_sts_len: assert property (p_sts_len)
    else $error("status strobe length wrong");
  property p_sts_new; $fell(STATUS_STROBE_N) |-> evt_q; endproperty
  a_sts_new: assert property (p_sts_new)
    else $error("status strobe without new status");
  property p_sts_hold; !STATUS_STROBE_N && !$fell(STATUS_STROBE_N) |-> $stable(PERIPH_BYTE_BUS_O);
  endproperty
  a_sts_hold: assert property (p_sts_hold)
    else $error("status byte moved during strobe");
  property p_sts_rdy; $fell(STATUS_STROBE_N) |->
    PERIPH_BYTE_BUS_O[pbp_pkg::READY_BIT] == $past(READY_N); endproperty
  a_sts_rdy: assert property (p_sts_rdy)
    else $error("status ready bit differs from ready pin");
  // fetch phase and bus ownership
  property p_rd_len; $fell(PERIPH_READ_STROBE_N) |=> !PERIPH_READ_STROBE_N [*4]; endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe too short");
  property p_excl; STATUS_STROBE_N || PERIPH_READ_STROBE_N; endproperty
  a_excl: assert property (p_excl)
    else $error("read and status strobes overlap");
  // write pacing
  property p_ack; wr |=> READY_N [*8] ##1 READY_N [*8] ##1 READY_N [*8] ##1 READY_N;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ready not held busy after write");
  property p_drop; WRITE_DROP |-> $past(wr) && READY_N; endproperty
  a_drop: assert property (p_drop)
    else $error("drop without write into full buffer");
  c_sts: cover property ($fell(STATUS_STROBE_N));
  c_drop: cover property (WRITE_DROP);
  c_b2b: cover property ($rose(PERIPH_READ_STROBE_N) ##[1:2] $fell(PERIPH_READ_STROBE_N));
endmodule : pbp_checker

// *** pbp_fifo.sv ***
// input byte buffer with registered read data
`timescale 1ns/1ns
module pbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("pbp_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    cnt_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;
  logic             push;
  logic             pop;
  logic [CW-1:0]    fill;

  ////////////////////////////////////////////////////////////////////////////
  // handshake terms; the output register counts as one slot, so DEPTH words fit in all
  assign fill      = cnt_q + CW'(ov_q);
  assign in_ready  = (fill != CW'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = (cnt_q != '0) && (!ov_q || out_ready);
  assign out_valid = ov_q;
  assign out_data  = od_q;

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // registered output stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (pop) begin
      ov_q <= 1'b1;
      od_q <= mem_q[rd_ptr_q];
    end else if (out_ready) begin
      ov_q <= 1'b0;
    end
  end

endmodule : pbp_fifo

// *** pbp_periph_model.sv ***
// peripheral that answers the device read strobe
`timescale 1ns/1ns
module pbp_periph_model (
  // clock and strobe
  input  wire logic       clk,
  input  wire logic       rd_n,
  // strobe cycles before the byte shows
  input  wire logic [1:0] lag,
  // level put on the bus
  output logic [7:0]      bus_d
);
  logic [7:0] byte_q = 8'hA0;
  logic [2:0] age_q  = 3'h0;
  logic       rd_q   = 1'b1;
  ////////////////////////////////////////
  // age the strobe and step the byte when it ends
  always_ff @(posedge clk) begin
    rd_q  <= rd_n;
    age_q <= rd_n ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
    if (rd_n && !rd_q) byte_q <= byte_q + 8'h01;
  end
  // byte only inside the strobe, inverse level otherwise
  assign bus_d = (!rd_n && age_q >= {1'b0, lag}) ? byte_q : ~byte_q;
endmodule : pbp_periph_model

// *** pbp_pkg.sv ***
// constants and carrier types for the peripheral byte port
package pbp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_NS       = 8;    // 125 MHz system clock
  localparam int STROBE_NS    = 40;   // least low time of the read and status strobes
  localparam int ACK_NS       = 200;  // least busy pulse on ready after each write
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACK_CYC      = (ACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // bus and status byte layout
  localparam int BYTE_W          = 8;
  localparam int READY_BIT       = 4;     // status_ready_bit position
  localparam int BUF_DEPTH_DEF   = 8192;  // input buffer size in bytes
  localparam logic [7:0] BYTE_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pbp_byte_xfer_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FETCH,
    PH_STATUS
  } pbp_phase_type;

endpackage : pbp_pkg

// *** peripheral_byte_port_tb_top.sv ***
// self-checking bench for the peripheral byte port
`timescale 1ns/1ns
module peripheral_byte_port_tb_top;
  logic       CLK, RST, wr_n, h_drv, fetch, sv, brdy, stall;
  logic       oe, sts_n, rd_n, rdy_n, busy, bval, drop;
  logic [7:0] h_d, sd, bus_i, bus_o, p_d, bdat, b, fb;
  logic [1:0] lag;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         n, k, w;
  logic [7:0] exp_q[$];
  ////////////////////////////////////////
  // clock, shared bus level and parties
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  assign bus_i = oe ? bus_o : (h_drv ? h_d : p_d);
  pbp_periph_model u_per (.clk(CLK), .rd_n(rd_n), .lag(lag), .bus_d(p_d));
  pbp_byte_port #(.BUF_DEPTH(16)) dut (
    .CLK(CLK), .RST(RST), .PERIPH_BYTE_BUS_I(bus_i), .PERIPH_BYTE_BUS_O(bus_o),
    .PERIPH_BYTE_BUS_OE(oe), .STATUS_STROBE_N(sts_n), .PERIPH_READ_STROBE_N(rd_n),
    .HOST_WRITE_STROBE_N(wr_n), .READY_N(rdy_n), .FETCH_REQ(fetch), .FETCH_BUSY(busy),
    .STATUS_VALID(sv), .STATUS_DATA(sd), .BYTE_VALID(bval), .BYTE_READY(brdy),
    .BYTE_DATA(bdat), .WRITE_DROP(drop));
  ////////////////////////////////////////
  // compare, wait and bus cycle tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // waits for FETCH_BUSY when on_busy is high, else for the status strobe
  task automatic wait_lvl(input logic on_busy, input logic v);
    for (int i = 0; i < 100 && (on_busy ? busy : sts_n) !== v; i++) @(negedge CLK);
    check(8'(on_busy ? busy : sts_n), 8'(v));
  endtask : wait_lvl
  task automatic host_wr(input logic [7:0] d);
    @(posedge CLK) begin
      wr_n  <= 1'b0;
      h_drv <= 1'b1;
      h_d   <= d;
    end
    @(posedge CLK) wr_n <= 1'b1;
    @(posedge CLK) h_drv <= 1'b0;
  endtask : host_wr
  // host pacing: ready low, then let the status phase pass
  task automatic ready_wait;
    @(negedge CLK);
    for (int i = 0; i < 40 && rdy_n; i++) @(negedge CLK);
    if (!rdy_n) begin
      repeat (3) @(negedge CLK);
      wait_lvl(1'b0, 1'b1);
    end
  endtask : ready_wait
  task automatic stat(input logic b4);
    @(posedge CLK) begin
      sv <= 1'b1;
      sd <= 8'($urandom);
    end
    @(posedge CLK) sv <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    check(bus_o, {sd[7:5], b4, sd[3:0]});
    check(8'(oe), 8'h01);
    n = 0;
    while (!sts_n && n < 20) begin
      n++;
      @(negedge CLK);
    end
    check(8'(n), 8'h05);
    repeat (10) @(negedge CLK);
    check(8'(sts_n), 8'h01);
  endtask : stat
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////
  // drain side: random taking, checked against the queue
  always @(posedge CLK) brdy <= !stall && ($urandom % 3 != 0);
  always @(negedge CLK) begin
    if (!RST && bval && brdy) check(bdat, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(32'h63EA));
    RST = 1'b1;
    wr_n = 1'b1;
    h_drv = 1'b0;
    h_d = 8'h00;
    fetch = 1'b0;
    sv = 1'b0;
    sd = 8'h00;
    stall = 1'b0;
    lag = 2'h3;
    fb = 8'hA0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    check({3'h0, oe, sts_n, rd_n, rdy_n, bval}, 8'h0C);
    stat(1'b0);
    $display("test status done");
    for (k = 0; k < 4; k++) begin
      ready_wait();
      check(8'(rdy_n), 8'h00);
      b = 8'($urandom);
      exp_q.push_back(b);
      host_wr(b);
      @(negedge CLK);
      check(8'(rdy_n), 8'h01);
      n = 0;
      while (rdy_n && n < 60) begin
        n++;
        @(negedge CLK);
      end
      check(8'(n), 8'h19);
    end
    $display("test write done");
    stall = 1'b1;
    for (w = 0; w < 20; w++) begin
      ready_wait();
      if (rdy_n) break;
      b = 8'($urandom);
      exp_q.push_back(b);
      host_wr(b);
    end
    check(8'(w), 8'h10);
    host_wr(8'h5A);
    @(negedge CLK);
    check({6'h0, drop, rdy_n}, 8'h03);
    stat(1'b1);
    stall = 1'b0;
    ready_wait();
    check(8'(rdy_n), 8'h00);
    $display("test full done");
    @(posedge CLK) fetch <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wait_lvl(1'b1, 1'b1);
      @(posedge CLK) fetch <= (k < 3);
      // second fetch: a host write rises on the edge that would end it
      if (k == 1) begin
        b = 8'($urandom);
        exp_q.push_back(b);
        @(posedge CLK);
        host_wr(b);
        @(negedge CLK);
        check(8'(busy), 8'h01);
      end
      exp_q.push_back(fb);
      fb++;
      wait_lvl(1'b1, 1'b0);
      @(posedge CLK) lag <= 2'($urandom);
    end
    repeat (80) @(negedge CLK);
    check(8'(exp_q.size()), 8'h00);
    $display("test fetch done");
    results();
  end
endmodule : peripheral_byte_port_tb_top

bind pbp_byte_port pbp_checker u_chk (
  .CLK(CLK), .RST(RST), .PERIPH_BYTE_BUS_O(PERIPH_BYTE_BUS_O),
  .PERIPH_BYTE_BUS_OE(PERIPH_BYTE_BUS_OE), .STATUS_STROBE_N(STATUS_STROBE_N),
  .PERIPH_READ_STROBE_N(PERIPH_READ_STROBE_N), .HOST_WRITE_STROBE_N(HOST_WRITE_STROBE_N),
  .READY_N(READY_N), .STATUS_VALID(STATUS_VALID), .WRITE_DROP(WRITE_DROP));
